/* File: design/pcr_bank.sv */
// Peripheral register bank with one receive and one transmit channel.
// Assumes the word bus samples on the core clock and memory acknowledges
// each held request with a one-cycle pulse.
`timescale 1ns/1ps
module pcr_bank import pcr_pkg::*; (
   input wire logic i_core_clk,           // Core clock, 100 MHz
   input wire logic i_nrst,               // Async reset, active low
   input wire logic i_ce,                 // Clock enable, freezes state
   input wire pcr_bus_s i_bus,            // Register access
   output logic [31:0] o_bus_rdata,       // Read data, next cycle
   output logic o_irq,                    // Interrupt source
   input wire logic i_rx_valid,           // Received word offered
   input wire logic [31:0] i_rx_data,     // Received word
   output logic o_rx_ready,               // Receive buffer has room
   output pcr_mem_s o_mem,                // Memory request
   input wire logic i_mem_ack,            // Memory done, one cycle
   input wire logic [31:0] i_mem_rdata,   // Memory read data
   output logic o_tx_valid,               // Word for transmitter
   output logic [31:0] o_tx_data,         // Transmit word
   input wire logic i_tx_ready            // Transmitter takes word
);

   // ==========================================================
   // State and decoded access
   pcr_state_s q, d;
   logic [13:0] word_addr;
   logic bus_wr, bus_rd;
   logic fifo_valid, fifo_pop, fifo_ready;
   logic [31:0] fifo_data;
   logic [PCR_SR_W-1:0] sr_d, sr_q;

   assign word_addr = {i_bus.addr[13:2], 2'b00};
   assign bus_wr = i_bus.sel && i_bus.wr;
   assign bus_rd = i_bus.sel && !i_bus.wr;

   assign sr_q = {q.tx_en, q.rx_en, q.tx_cnt == '0, q.rx_cnt == '0};
   assign sr_d = {d.tx_en, d.rx_en, d.tx_cnt == '0, d.rx_cnt == '0};

   // ==========================================================
   // Receive buffer; its ready is the source's back-pressure
   // one channel pair per port instance
   pcr_fifo #(
      .WIDTH(PCR_FIFO_WIDTH),
      .DEPTH(PCR_FIFO_DEPTH)
   ) u_rx_fifo (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_ce(i_ce),
      .i_wr_valid(i_rx_valid),
      .o_wr_ready(fifo_ready),
      .i_wr_data(i_rx_data),
      .o_rd_valid(fifo_valid),
      .i_rd_ready(fifo_pop),
      .o_rd_data(fifo_data)
   );

   // ==========================================================
   // Next state of the whole bank
   always_comb begin
      d = q;
      fifo_pop = 1'b0;
      if (i_ce) begin
         // Channel sequencer; receive wins so its buffer drains first
         unique case (q.fsm)
            PCR_IDLE: begin
               if (q.rx_en && !q.mode[PCR_MR_RXHOLD] &&
                   q.rx_cnt != '0 && fifo_valid) begin
                  fifo_pop = 1'b1;
                  d.mem = '{req: 1'b1, we: 1'b1, addr: q.rx_ptr,
                            wdata: fifo_data};
                  d.fsm = PCR_RXW;
               end else if (q.tx_en && !q.mode[PCR_MR_TXHOLD] &&
                            q.tx_cnt != '0) begin
                  d.mem = '{req: 1'b1, we: 1'b0, addr: q.tx_ptr,
                            wdata: 32'h0000_0000};
                  d.fsm = PCR_TXR;
               end
            end
            PCR_RXW: begin
               if (i_mem_ack) begin
                  d.mem.req = 1'b0;
                  d.rx_ptr = q.rx_ptr + PCR_XFER_BYTES;
                  d.rx_cnt = q.rx_cnt - PCR_CNT_ONE;
                  d.fsm = PCR_IDLE;
               end
            end
            PCR_TXR: begin
               if (i_mem_ack) begin
                  d.mem.req = 1'b0;
                  d.tx_data = i_mem_rdata;
                  d.tx_valid = 1'b1;
                  d.tx_ptr = q.tx_ptr + PCR_XFER_BYTES;
                  d.tx_cnt = q.tx_cnt - PCR_CNT_ONE;
                  d.fsm = PCR_TXO;
               end
            end
            PCR_TXO: begin
               // Word held until the transmitter takes it
               if (i_tx_ready) begin
                  d.tx_valid = 1'b0;
                  d.fsm = PCR_IDLE;
               end
            end
         endcase

         // Software writes come last so they win over the sequencer
         if (bus_wr) begin
            unique case (word_addr)
               PCR_OFF_CR: begin
                  if (i_bus.wdata[PCR_CR_RXEN]) d.rx_en = 1'b1;
                  if (i_bus.wdata[PCR_CR_TXEN]) d.tx_en = 1'b1;
                  // Disable beats enable when both are written
                  if (i_bus.wdata[PCR_CR_RXDIS]) d.rx_en = 1'b0;
                  if (i_bus.wdata[PCR_CR_TXDIS]) d.tx_en = 1'b0;
               end
               PCR_OFF_MR: begin
                  d.mode = i_bus.wdata[PCR_MR_W-1:0];
               end
               PCR_OFF_IER: begin
                  d.imr = q.imr | i_bus.wdata[PCR_SR_W-1:0];
               end
               PCR_OFF_IDR: begin
                  d.imr = q.imr & ~i_bus.wdata[PCR_SR_W-1:0];
               end
               PCR_OFF_RXP: d.rx_ptr = i_bus.wdata;
               PCR_OFF_RXC: d.rx_cnt = i_bus.wdata[15:0];
               PCR_OFF_TXP: d.tx_ptr = i_bus.wdata;
               PCR_OFF_TXC: d.tx_cnt = i_bus.wdata[15:0];
               default: begin
               end
            endcase
         end

         // Read data, unused bits forced to zero
         if (bus_rd) begin
            unique case (word_addr)
               PCR_OFF_MR: d.rdata = {30'h0000_0000, q.mode};
               PCR_OFF_IMR: d.rdata = {28'h000_0000, q.imr};
               PCR_OFF_SR: d.rdata = {28'h000_0000, sr_q};
               PCR_OFF_RXP: d.rdata = q.rx_ptr;
               PCR_OFF_RXC: d.rdata = {16'h0000, q.rx_cnt};
               PCR_OFF_TXP: d.rdata = q.tx_ptr;
               PCR_OFF_TXC: d.rdata = {16'h0000, q.tx_cnt};
               default: d.rdata = 32'h0000_0000;
            endcase
         end

         d.irq = |(sr_d & d.imr);
      end
   end

   // ==========================================================
   // State register; reset zeroes the mode among all else
   // mode clears on reset
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         q <= PCR_STATE_RST;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from flops
   assign o_bus_rdata = q.rdata;
   assign o_irq = q.irq;
   assign o_mem = q.mem;
   assign o_tx_valid = q.tx_valid;
   assign o_tx_data = q.tx_data;
   assign o_rx_ready = fifo_ready;

   // ==========================================================
   // Checks
   sequence ier_write_s;
      i_ce && bus_wr && word_addr == PCR_OFF_IER;
   endsequence

   sequence idr_write_s;
      i_ce && bus_wr && word_addr == PCR_OFF_IDR;
   endsequence

   sequence rx_ack_s;
      i_ce && q.fsm == PCR_RXW && i_mem_ack && !bus_wr;
   endsequence

   sequence tx_ack_s;
      i_ce && q.fsm == PCR_TXR && i_mem_ack && !bus_wr;
   endsequence

   sequence mem_wait_s;
      i_ce && o_mem.req && !i_mem_ack;
   endsequence

   sequence tx_stall_s;
      i_ce && o_tx_valid && !i_tx_ready;
   endsequence

   sequence rx_issue_s;
      q.fsm == PCR_IDLE ##1 q.fsm == PCR_RXW;
   endsequence

   sequence tx_issue_s;
      q.fsm == PCR_IDLE ##1 q.fsm == PCR_TXR;
   endsequence

   irq_combine_a: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      o_irq == |(sr_q & q.imr))
      else $error("interrupt does not match masked status");

   mask_set_a: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      ier_write_s |=> (q.imr & $past(i_bus.wdata[PCR_SR_W-1:0])) ==
         $past(i_bus.wdata[PCR_SR_W-1:0]))
      else $error("enable write did not set mask bits");

   mask_clear_a: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      idr_write_s |=> (q.imr & $past(i_bus.wdata[PCR_SR_W-1:0])) == '0)
      else $error("disable write did not clear mask bits");

   mask_others_a: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      (ier_write_s or idr_write_s) |=>
         ((q.imr ^ $past(q.imr)) & ~$past(i_bus.wdata[PCR_SR_W-1:0]))
         == '0)
      else $error("zero bit changed the mask");

   mask_stable_a: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      !(i_ce && bus_wr && (word_addr == PCR_OFF_IER ||
        word_addr == PCR_OFF_IDR)) |=> $stable(q.imr))
      else $error("mask changed without enable or disable write");

   rx_advance_a: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      rx_ack_s |=> q.rx_cnt == $past(q.rx_cnt) - PCR_CNT_ONE &&
         q.rx_ptr == $past(q.rx_ptr) + PCR_XFER_BYTES)
      else $error("receive channel did not advance");

   rx_stop_a: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      q.fsm == PCR_IDLE && q.rx_cnt == '0 |=> q.fsm != PCR_RXW)
      else $error("receive channel ran at zero count");

   end_flag_a: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      i_ce && bus_rd && word_addr == PCR_OFF_SR && q.tx_cnt == '0
      |=> o_bus_rdata[PCR_SR_TXEND])
      else $error("end of transfer not reported");

   unused_zero_a: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      i_ce && bus_rd && word_addr == PCR_OFF_MR
      |=> o_bus_rdata[31:PCR_MR_W] == '0)
      else $error("unused mode bits read nonzero");

   cmd_zero_a: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      i_ce && bus_wr && word_addr == PCR_OFF_CR && i_bus.wdata == '0
      |=> $stable(q.rx_en) && $stable(q.tx_en))
      else $error("zero command changed channel state");

   status_ro_a: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      i_ce && bus_wr && word_addr == PCR_OFF_SR && q.fsm == PCR_IDLE &&
      !q.rx_en && !q.tx_en |=> $stable(sr_q))
      else $error("status changed by a write");

   tx_advance_a: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      tx_ack_s |=> q.tx_cnt == $past(q.tx_cnt) - PCR_CNT_ONE &&
         q.tx_ptr == $past(q.tx_ptr) + PCR_XFER_BYTES && o_tx_valid)
      else $error("transmit channel did not advance");

   tx_stop_a: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      q.fsm == PCR_IDLE && q.tx_cnt == '0 |=> q.fsm != PCR_TXR)
      else $error("transmit channel ran at zero count");

   // Memory side may stall; the request must not move meanwhile
   mem_hold_a: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      mem_wait_s |=> o_mem.req && $stable(o_mem))
      else $error("memory request changed before completion");

   tx_hold_a: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      tx_stall_s |=> o_tx_valid && $stable(o_tx_data))
      else $error("transmit word dropped before taken");

   rx_issue_a: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      rx_issue_s |-> o_mem.req && o_mem.we &&
         o_mem.addr == $past(q.rx_ptr))
      else $error("receive request not at pointer");

   tx_issue_a: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      tx_issue_s |-> o_mem.req && !o_mem.we &&
         o_mem.addr == $past(q.tx_ptr))
      else $error("transmit request not at pointer");

   cmd_start_a: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      i_ce && bus_wr && word_addr == PCR_OFF_CR &&
      i_bus.wdata[PCR_CR_RXEN] && !i_bus.wdata[PCR_CR_RXDIS]
      |=> q.rx_en)
      else $error("receive start command ignored");

   cmd_stop_a: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      i_ce && bus_wr && word_addr == PCR_OFF_CR &&
      i_bus.wdata[PCR_CR_TXDIS] |=> !q.tx_en)
      else $error("transmit stop command ignored");

   // Hold bit keeps the channel from starting a new word
   mode_hold_a: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      q.fsm == PCR_IDLE && q.mode[PCR_MR_RXHOLD] |=> q.fsm != PCR_RXW)
      else $error("receive channel ran while held");

   status_read_a: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      i_ce && bus_rd && word_addr == PCR_OFF_SR
      |=> o_bus_rdata == {28'h000_0000, $past(sr_q)})
      else $error("status read does not show condition");

   mask_read_a: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      i_ce && bus_rd && word_addr == PCR_OFF_IMR
      |=> o_bus_rdata == {28'h000_0000, $past(q.imr)})
      else $error("mask read does not show mask");

   rx_end_a: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      i_ce && bus_rd && word_addr == PCR_OFF_SR && q.rx_cnt == '0
      |=> o_bus_rdata[PCR_SR_RXEND])
      else $error("receive end of transfer not reported");

endmodule

/* File: design/pcr_pkg.sv */
// Constants, carriers and state layout of the peripheral register bank.
// Assumes one core clock and a word-wide peripheral bus. The bank drives
// a simple word-wide memory port.
package pcr_pkg;

   // ==========================================================
   // Register byte offsets
   localparam logic [13:0] PCR_OFF_CR = 14'h0000;  // Command, write only
   localparam logic [13:0] PCR_OFF_MR = 14'h0004;  // Mode
   localparam logic [13:0] PCR_OFF_IER = 14'h0008; // Interrupt enable
   localparam logic [13:0] PCR_OFF_IDR = 14'h000c; // Interrupt disable
   localparam logic [13:0] PCR_OFF_IMR = 14'h0010; // Interrupt mask
   localparam logic [13:0] PCR_OFF_SR = 14'h0014;  // Status
   localparam logic [13:0] PCR_OFF_RXP = 14'h0030; // Receive pointer
   localparam logic [13:0] PCR_OFF_RXC = 14'h0034; // Receive count
   localparam logic [13:0] PCR_OFF_TXP = 14'h0038; // Transmit pointer
   localparam logic [13:0] PCR_OFF_TXC = 14'h003c; // Transmit count

   // ==========================================================
   // Field positions
   localparam int PCR_CR_RXEN = 0;   // Start receive channel
   localparam int PCR_CR_RXDIS = 1;  // Stop receive channel
   localparam int PCR_CR_TXEN = 2;   // Start transmit channel
   localparam int PCR_CR_TXDIS = 3;  // Stop transmit channel
   localparam int PCR_MR_RXHOLD = 0; // Pause receive channel
   localparam int PCR_MR_TXHOLD = 1; // Pause transmit channel
   localparam int PCR_SR_RXEND = 0;  // Receive count is zero
   localparam int PCR_SR_TXEND = 1;  // Transmit count is zero
   localparam int PCR_SR_RXON = 2;   // Receive channel enabled
   localparam int PCR_SR_TXON = 3;   // Transmit channel enabled
   localparam int PCR_SR_W = 4;
   localparam int PCR_MR_W = 2;

   // ==========================================================
   // Counts and reset values
   localparam logic [31:0] PCR_XFER_BYTES = 32'h0000_0004;
   localparam logic [15:0] PCR_CNT_ONE = 16'h0001;
   localparam int PCR_FIFO_DEPTH = 16;
   localparam int PCR_FIFO_WIDTH = 32;
   localparam logic [PCR_MR_W-1:0] PCR_MR_RST = 2'h0;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic sel;          // Access strobe, one cycle
      logic wr;           // One for write, zero for read
      logic [13:0] addr;  // Byte address
      logic [31:0] wdata; // Write data
   } pcr_bus_s;

   typedef struct packed {
      logic req;          // Held until acknowledged
      logic we;           // One for write
      logic [31:0] addr;  // Word address in bytes
      logic [31:0] wdata; // Write data
   } pcr_mem_s;

   typedef enum logic [1:0] {
      PCR_IDLE,
      PCR_RXW,
      PCR_TXR,
      PCR_TXO
   } pcr_fsm_e;

   typedef struct packed {
      pcr_fsm_e fsm;
      logic [PCR_MR_W-1:0] mode;
      logic [PCR_SR_W-1:0] imr;
      logic rx_en;
      logic tx_en;
      logic [31:0] rx_ptr;
      logic [15:0] rx_cnt;
      logic [31:0] tx_ptr;
      logic [15:0] tx_cnt;
      pcr_mem_s mem;
      logic [31:0] tx_data;
      logic tx_valid;
      logic [31:0] rdata;
      logic irq;
   } pcr_state_s;

   localparam pcr_state_s PCR_STATE_RST = '0;

endpackage

/* File: design/pcr_fifo.sv */
// Synchronous FIFO with valid and ready on both sides.
// Assumes a single clock; clock enable low freezes all state.
`timescale 1ns/1ps
module pcr_fifo import pcr_pkg::*; #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input wire logic i_core_clk,          // Core clock
   input wire logic i_nrst,              // Async reset, active low
   input wire logic i_ce,                // Clock enable
   input wire logic i_wr_valid,          // Push request
   output logic o_wr_ready,              // Not full, from flop
   input wire logic [WIDTH-1:0] i_wr_data, // Push data
   output logic o_rd_valid,              // Not empty, from flop
   input wire logic i_rd_ready,          // Pop request
   output logic [WIDTH-1:0] o_rd_data    // Head word
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [AW:0] count;
      logic ready; // Room left, kept as a flop so the port is registered
      logic valid; // Head word present
   } pcr_fifo_s;

   pcr_fifo_s q, d;
   logic push, pop;

   // ==========================================================
   // Next state; flags follow the next count so they are flops
   always_comb begin
      d = q;
      push = i_ce && i_wr_valid && q.ready;
      pop = i_ce && i_rd_ready && q.valid;
      if (push) begin
         d.mem[q.wptr] = i_wr_data;
         d.wptr = q.wptr + 1'b1;
      end
      if (pop) begin
         d.rptr = q.rptr + 1'b1;
      end
      d.count = q.count + (AW+1)'(push) - (AW+1)'(pop);
      d.ready = (d.count != (AW+1)'(DEPTH));
      d.valid = (d.count != '0);
   end

   // Reset leaves the queue empty
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         q <= '{default: '0, ready: 1'b1};
      end else begin
         q <= d;
      end
   end

   assign o_wr_ready = q.ready;
   assign o_rd_valid = q.valid;
   assign o_rd_data = q.mem[q.rptr];

endmodule

/* File: sim/pcr_mem_model.sv */
// Behavioural memory that answers the bank's memory port.
// Assumes one outstanding request, held by the bank until acknowledged.
`timescale 1ns/1ps
module pcr_mem_model import pcr_pkg::*; (
   input wire logic i_core_clk,     // Core clock
   input wire logic i_nrst,         // Async reset, active low
   input wire pcr_mem_s i_mem,      // Request from the bank
   input wire logic [3:0] i_delay,  // Wait cycles before ack
   output logic o_ack,              // One-cycle completion
   output logic [31:0] o_rdata      // Read data, valid with ack
);
   logic [31:0] mem [0:255];
   logic [3:0] wait_q;
   int wr_count;
   // ==========================================
   // Ack after the wait; data churns outside ack so late samples show
   always @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_ack <= 1'b0;
         wait_q <= 4'h0;
         o_rdata <= 32'h0000_0000;
         wr_count <= 0;
      end else if (o_ack) begin
         o_ack <= 1'b0;
         wait_q <= 4'h0;
         o_rdata <= ~o_rdata;
      end else if (i_mem.req && wait_q >= i_delay) begin
         o_ack <= 1'b1;
         if (i_mem.we) begin
            mem[i_mem.addr[9:2]] <= i_mem.wdata;
            wr_count <= wr_count + 1;
         end else begin
            o_rdata <= mem[i_mem.addr[9:2]];
         end
      end else begin
         o_rdata <= ~o_rdata;
         if (i_mem.req) wait_q <= wait_q + 4'h1;
      end
   end
endmodule

/* File: sim/pcr_bank_tb.sv */
// Self-checking bench for the peripheral register bank.
// Assumes the memory model answers the memory port; inputs move at negedge.
`timescale 1ns/1ps
module pcr_bank_tb import pcr_pkg::*;;
   logic i_core_clk = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   pcr_bus_s bus = '0;
   logic [31:0] rdata;
   logic irq, rx_valid = 1'b0, rx_ready, mem_ack, tx_valid, tx_ready = 1'b0;
   logic [31:0] rx_data = 32'h0000_0000, mem_rdata, tx_data;
   logic [3:0] mdelay = 4'h0;
   pcr_mem_s mem;
   int fails = 0, checks_done = 0;
   // ==========================================
   // Clock and units under test
   always #5 i_core_clk = ~i_core_clk;
   pcr_bank pcr_bank_inst (.i_core_clk(i_core_clk), .i_nrst(nrst),
      .i_ce(ce), .i_bus(bus), .o_bus_rdata(rdata), .o_irq(irq),
      .i_rx_valid(rx_valid), .i_rx_data(rx_data), .o_rx_ready(rx_ready),
      .o_mem(mem), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata),
      .o_tx_valid(tx_valid), .o_tx_data(tx_data), .i_tx_ready(tx_ready));
   pcr_mem_model pcr_mem_model_inst (.i_core_clk(i_core_clk),
      .i_nrst(nrst), .i_mem(mem), .i_delay(mdelay), .o_ack(mem_ack),
      .o_rdata(mem_rdata));
   // ==========================================
   // Shared helpers
   function automatic logic [31:0] bitv(input int n);
      return 32'h0000_0001 << n;
   endfunction
   task automatic chk(input logic [31:0] seen, exp, input string msg);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %0t %s seen %h want %h", $time, msg, seen,
                  exp);
      end
   endtask
   // One-cycle strobe; read data is settled at the following negedge
   task automatic acc(input logic wr, input logic [13:0] a,
                      input logic [31:0] d, output logic [31:0] rd);
      @(negedge i_core_clk);
      bus = '{1'b1, wr, a, d};
      @(negedge i_core_clk);
      bus.sel = 1'b0;
      rd = rdata;
   endtask
   task automatic wr(input logic [13:0] a, input logic [31:0] d);
      logic [31:0] rd;
      acc(1'b1, a, d, rd);
   endtask
   task automatic rd_chk(input logic [13:0] a, input logic [31:0] exp,
                         input string msg);
      logic [31:0] rd;
      acc(1'b0, a, 32'h0000_0000, rd);
      chk(rd, exp, msg);
   endtask
   // Offer a word and hold it until the buffer takes it
   task automatic push(input logic [31:0] w, output logic ok);
      @(negedge i_core_clk);
      rx_valid = 1'b1;
      rx_data = w;
      ok = 1'b0;
      for (int k = 0; k < 40 && !ok; k++) begin
         ok = rx_ready;
         @(negedge i_core_clk);
      end
      rx_valid = 1'b0;
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset;
      logic [13:0] offs [4];
      offs = '{PCR_OFF_RXP, PCR_OFF_RXC, PCR_OFF_TXP, PCR_OFF_TXC};
      rd_chk(PCR_OFF_MR, 32'h0000_0000, "mode reset");
      rd_chk(PCR_OFF_IMR, 32'h0000_0000, "mask reset");
      rd_chk(PCR_OFF_SR, bitv(PCR_SR_RXEND) | bitv(PCR_SR_TXEND), "sr");
      foreach (offs[i]) rd_chk(offs[i], 32'h0000_0000, "chan reset");
      chk({31'h0, irq}, 32'h0000_0000, "irq reset");
   endtask
   task automatic t_regs;
      logic [31:0] ends;
      ends = bitv(PCR_SR_RXEND) | bitv(PCR_SR_TXEND);
      wr(PCR_OFF_MR, 32'hffff_ffff);
      rd_chk(PCR_OFF_MR, 32'h0000_0003, "mode unused bits");
      ce = 1'b0;
      wr(PCR_OFF_MR, 32'h0000_0000);
      ce = 1'b1;
      rd_chk(PCR_OFF_MR, 32'h0000_0003, "clock enable low");
      wr(PCR_OFF_MR, 32'h0000_0000);
      rd_chk(PCR_OFF_MR, 32'h0000_0000, "mode clear");
      rd_chk(PCR_OFF_CR, 32'h0000_0000, "command reads zero");
      rd_chk(14'h0100, 32'h0000_0000, "unmapped reads zero");
      wr(PCR_OFF_SR, 32'h0000_000f);
      rd_chk(PCR_OFF_SR, ends, "status write ignored");
      wr(PCR_OFF_IER, bitv(PCR_SR_RXON));
      wr(PCR_OFF_IER, bitv(PCR_SR_TXON));
      rd_chk(PCR_OFF_IMR, 32'h0000_000c, "enable keeps bits");
      repeat (2) @(negedge i_core_clk);
      chk({31'h0, irq}, 32'h0000_0000, "irq masked out");
      wr(PCR_OFF_IER, bitv(PCR_SR_RXEND));
      rd_chk(PCR_OFF_IMR, 32'h0000_000d, "enable sets");
      chk({31'h0, irq}, 32'h0000_0001, "irq raised");
      wr(PCR_OFF_IDR, bitv(PCR_SR_RXEND));
      rd_chk(PCR_OFF_IMR, 32'h0000_000c, "disable clears");
      chk({31'h0, irq}, 32'h0000_0000, "irq dropped");
      wr(PCR_OFF_IMR, 32'h0000_000f);
      rd_chk(PCR_OFF_IMR | 14'h0003, 32'h0000_000c, "mask byte addr");
      wr(PCR_OFF_IDR, 32'h0000_000c);
   endtask
   // Fill until refused, then drain into a slow memory
   task automatic t_rx;
      logic ok;
      logic [31:0] rd;
      int n;
      for (int i = 0; i < 16; i++) begin
         push(32'ha000_0000 + i, ok);
         chk({31'h0, ok}, 32'h0000_0001, "fifo room");
      end
      chk({31'h0, rx_ready}, 32'h0000_0000, "fifo full");
      wr(PCR_OFF_RXP, 32'h0000_0100);
      wr(PCR_OFF_RXC, 32'h0000_0010);
      mdelay = 4'h3;
      // Held channel must not move although enabled
      wr(PCR_OFF_MR, bitv(PCR_MR_RXHOLD));
      wr(PCR_OFF_CR, bitv(PCR_CR_RXEN));
      wr(PCR_OFF_CR, 32'h0000_0000);
      acc(1'b0, PCR_OFF_SR, 32'h0000_0000, rd);
      chk(rd & bitv(PCR_SR_RXON), bitv(PCR_SR_RXON), "rx on");
      rd_chk(PCR_OFF_RXC, 32'h0000_0010, "rx held");
      wr(PCR_OFF_MR, 32'h0000_0000);
      for (n = 0; n < 300 && !rd[PCR_SR_RXEND]; n++)
         acc(1'b0, PCR_OFF_SR, 32'h0000_0000, rd);
      chk(rd & bitv(PCR_SR_RXEND), bitv(PCR_SR_RXEND), "rx end");
      for (int i = 0; i < 16; i++)
         chk(pcr_mem_model_inst.mem[64 + i], 32'ha000_0000 + i,
             "rx word");
      rd_chk(PCR_OFF_RXP, 32'h0000_0140, "rx pointer");
      rd_chk(PCR_OFF_RXC, 32'h0000_0000, "rx count");
      chk({31'h0, rx_ready}, 32'h0000_0001, "fifo drained");
      push(32'h0000_5555, ok);
      repeat (20) @(negedge i_core_clk);
      chk(pcr_mem_model_inst.wr_count, 16, "stops at zero");
      wr(PCR_OFF_CR, bitv(PCR_CR_RXDIS));
      rd_chk(PCR_OFF_SR, bitv(PCR_SR_RXEND) | bitv(PCR_SR_TXEND),
             "rx off");
   endtask
   // Transmit with a stalling receiver
   task automatic t_tx;
      int n;
      for (int i = 0; i < 3; i++)
         pcr_mem_model_inst.mem[128 + i] = 32'hc0de_0000 + i;
      wr(PCR_OFF_TXP, 32'h8000_0200);
      rd_chk(PCR_OFF_TXP, 32'h8000_0200, "tx pointer width");
      wr(PCR_OFF_TXC, 32'hffff_0003);
      rd_chk(PCR_OFF_TXC, 32'h0000_0003, "tx count width");
      mdelay = 4'h0;
      wr(PCR_OFF_CR, bitv(PCR_CR_TXEN));
      n = 0;
      for (int k = 0; k < 300 && n < 3; k++) begin
         @(negedge i_core_clk);
         tx_ready = (k % 3 != 0);
         if (tx_valid && tx_ready) begin
            chk(tx_data, 32'hc0de_0000 + n, "tx word");
            n++;
         end
      end
      @(negedge i_core_clk);
      tx_ready = 1'b0;
      chk(n, 3, "tx words");
      rd_chk(PCR_OFF_TXP, 32'h8000_020c, "tx pointer end");
      rd_chk(PCR_OFF_TXC, 32'h0000_0000, "tx count end");
      wr(PCR_OFF_CR, bitv(PCR_CR_TXDIS));
      rd_chk(PCR_OFF_SR, bitv(PCR_SR_RXEND) | bitv(PCR_SR_TXEND),
             "tx end");
   endtask
   // Reset in mid-run brings mode and mask back to zero
   task automatic t_rerun;
      wr(PCR_OFF_MR, 32'h0000_0003);
      wr(PCR_OFF_IER, 32'h0000_000f);
      @(negedge i_core_clk);
      nrst = 1'b0;
      @(negedge i_core_clk);
      nrst = 1'b1;
      rd_chk(PCR_OFF_MR, 32'h0000_0000, "mode after reset");
      rd_chk(PCR_OFF_IMR, 32'h0000_0000, "mask after reset");
      chk({31'h0, irq}, 32'h0000_0000, "irq after reset");
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ==========================================
   // Main sequence; watchdog allows about seventy times the expected run
   initial begin
      repeat (3) @(negedge i_core_clk);
      nrst = 1'b1;
      t_reset();
      t_regs();
      t_rx();
      t_tx();
      t_rerun();
      conclude();
   end
   initial begin
      #200000;
      fails++;
      conclude();
   end
endmodule
